// ---- hw/lowpower_cal_sleep_wake.sv ----
// low-power background calibration sleep and wake scheduler
`timescale 1ns/1ps
`include "lowpower_cal_map.svh"

// Operation
// - calibration off while enable bit is 0; also needs background enable
// - trigger-mode 0: each core sleeps the programmed interval, then wakes
// - trigger-mode 1: cores sleep until the calibration trigger is low
// - sleep code selects (2^N+1)x256 periods, N 3,15,18,21,24,27,30,33
// - settle code selects (2^N+1)x256 periods, N 33,18,21,24
// - control register at 0x6e, reset 0x88, all bits read/write
// - source select 0 uses software bit, 1 uses hardware pin
module lowpower_cal_sleep_wake #(
    parameter int unsigned NUM_CORES = 2,
    parameter logic [7:0][`LPC_CNT_W-1:0] SLEEP_CYCLES = {
        `LPC_SLEEP_CNT_7, `LPC_SLEEP_CNT_6, `LPC_SLEEP_CNT_5,
        `LPC_SLEEP_CNT_4, `LPC_SLEEP_CNT_3, `LPC_SLEEP_CNT_2,
        `LPC_SLEEP_CNT_1, `LPC_SLEEP_CNT_0},
    parameter logic [3:0][`LPC_CNT_W-1:0] SETTLE_CYCLES = {
        `LPC_SETTLE_CNT_3, `LPC_SETTLE_CNT_2,
        `LPC_SETTLE_CNT_1, `LPC_SETTLE_CNT_0}
) (
    input  wire logic                 clk_sys_i,
    input  wire logic                 rst_i,
    input  wire logic [7:0]           reg_addr_i,
    input  wire logic [7:0]           reg_wdata_i,
    input  wire logic                 reg_wr_i,
    input  wire logic                 reg_rd_i,
    output logic      [7:0]           reg_rdata_o,
    input  wire logic                 hardware_trigger_pin_i,
    input  wire logic [NUM_CORES-1:0] cal_done_i,
    output logic      [NUM_CORES-1:0] core_awake_o,
    output logic      [NUM_CORES-1:0] cal_start_o
);

    // ***********************************************************
    // register file
    // ***********************************************************
    logic [7:0]                   lowpower_cal_control_reg;
    logic                         trigger_source_sel_reg;
    logic                         software_trigger_bit_reg;
    logic                         background_cal_enable_reg;
    logic [7:0]                   rdata_reg;
    lowpower_cal_pkg::lpc_state_t state_reg;
    lowpower_cal_pkg::lpc_state_t state_next;
    logic [`LPC_CNT_W-1:0]        cnt_reg;
    logic [`LPC_CNT_W-1:0]        cnt_next;
    logic                         core_reg;
    logic [NUM_CORES-1:0]         awake_reg;
    logic [NUM_CORES-1:0]         start_reg;

    wire logic wr_ctrl   = reg_wr_i && (reg_addr_i == `LPC_ADDR_CONTROL);
    wire logic wr_pin    = reg_wr_i && (reg_addr_i == `LPC_ADDR_PIN_CFG);
    wire logic wr_soft   = reg_wr_i && (reg_addr_i == `LPC_ADDR_SOFT_TRIG);
    wire logic wr_bg     = reg_wr_i && (reg_addr_i == `LPC_ADDR_BG_CTRL);
    wire logic [7:0] status_word = {3'h0, core_reg, 2'(awake_reg),
                                    2'(state_reg)};
    wire logic [7:0] src_word    = {7'h0, trigger_source_sel_reg};
    wire logic [7:0] soft_word   = {7'h0, software_trigger_bit_reg};
    wire logic [7:0] bg_word     = {7'h0, background_cal_enable_reg};
    wire logic [7:0] rd_word =
        (reg_addr_i == `LPC_ADDR_CONTROL)   ? lowpower_cal_control_reg :
        (reg_addr_i == `LPC_ADDR_PIN_CFG)   ? src_word :
        (reg_addr_i == `LPC_ADDR_SOFT_TRIG) ? soft_word :
        (reg_addr_i == `LPC_ADDR_BG_CTRL)   ? bg_word :
        (reg_addr_i == `LPC_ADDR_STATUS)    ? status_word :
                                              `LPC_RDATA_IDLE;

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            lowpower_cal_control_reg  <= `LPC_RST_CONTROL;
            trigger_source_sel_reg    <= `LPC_RST_PIN_CFG;
            software_trigger_bit_reg  <= `LPC_RST_SOFT_TRIG;
            background_cal_enable_reg <= `LPC_RST_BG_CTRL;
        end
        else
        begin
            if (wr_ctrl)
                lowpower_cal_control_reg <= reg_wdata_i;
            if (wr_pin)
                trigger_source_sel_reg <= reg_wdata_i[0];
            if (wr_soft)
                software_trigger_bit_reg <= reg_wdata_i[0];
            if (wr_bg)
                background_cal_enable_reg <= reg_wdata_i[0];
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
            rdata_reg <= `LPC_RDATA_IDLE;
        else
            rdata_reg <= reg_rd_i ? rd_word : `LPC_RDATA_IDLE;
    end
    assign reg_rdata_o = rdata_reg;

    // ***********************************************************
    // decode of control fields
    // ***********************************************************
    wire logic [2:0] sleep_sel =
        lowpower_cal_control_reg[`LPC_SLEEP_MSB:`LPC_SLEEP_LSB];
    wire logic [1:0] settle_sel =
        lowpower_cal_control_reg[`LPC_SETTLE_MSB:`LPC_SETTLE_LSB];
    wire logic trig_mode = lowpower_cal_control_reg[`LPC_TRIG_MODE_BIT];
    wire logic active = lowpower_cal_control_reg[`LPC_ENABLE_BIT] &&
                        background_cal_enable_reg;
    wire logic [`LPC_CNT_W-1:0] sleep_target = SLEEP_CYCLES[sleep_sel];
    wire logic [`LPC_CNT_W-1:0] settle_target = SETTLE_CYCLES[settle_sel];
    wire logic trig_level = trigger_source_sel_reg ? hardware_trigger_pin_i
                                                   : software_trigger_bit_reg;
    wire logic sleep_over  = (cnt_reg == sleep_target - `LPC_CNT_W'(1));
    wire logic settle_over = (cnt_reg == settle_target - `LPC_CNT_W'(1));
    wire logic core_done   = cal_done_i[core_reg];
    // trigger low wakes, interval expiry wakes
    wire logic wake_now = trig_mode ? !trig_level : sleep_over;

    // ***********************************************************
    // sleep, settle, calibrate sequencer
    // ***********************************************************
    always_comb
    begin
        state_next = state_reg;
        cnt_next   = cnt_reg + `LPC_CNT_W'(1);
        unique case (state_reg)
            lowpower_cal_pkg::ST_IDLE:
            begin
                cnt_next = '0;
                if (active)
                    state_next = lowpower_cal_pkg::ST_SLEEP;
            end
            lowpower_cal_pkg::ST_SLEEP:
                if (wake_now)
                begin
                    state_next = lowpower_cal_pkg::ST_SETTLE;
                    cnt_next   = '0;
                end
            lowpower_cal_pkg::ST_SETTLE:
                if (settle_over)
                begin
                    state_next = lowpower_cal_pkg::ST_CAL;
                    cnt_next   = '0;
                end
            lowpower_cal_pkg::ST_CAL:
            begin
                cnt_next = '0;
                if (core_done)
                    state_next = lowpower_cal_pkg::ST_SLEEP;
            end
        endcase
        // disable aborts the sequence at once
        if (!active)
        begin
            state_next = lowpower_cal_pkg::ST_IDLE;
            cnt_next   = '0;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            state_reg <= lowpower_cal_pkg::ST_IDLE;
            cnt_reg   <= '0;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
        end
    end

    // cores take turns so only one is ever off its sleep at a time
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
            core_reg <= 1'b0;
        else if (active && state_reg == lowpower_cal_pkg::ST_CAL && core_done)
            core_reg <= ~core_reg;
    end

    // ***********************************************************
    // per-core wake and start outputs
    // ***********************************************************
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CORES; gi++)
        begin : g_core
            always_ff @(posedge clk_sys_i)
            begin
                if (rst_i)
                begin
                    awake_reg[gi] <= 1'b0;
                    start_reg[gi] <= 1'b0;
                end
                else
                begin
                    awake_reg[gi] <= (core_reg == 1'(gi)) &&
                        (state_next == lowpower_cal_pkg::ST_SETTLE ||
                         state_next == lowpower_cal_pkg::ST_CAL);
                    start_reg[gi] <= (core_reg == 1'(gi)) && active &&
                        state_reg == lowpower_cal_pkg::ST_SETTLE &&
                        settle_over;
                end
            end
        end
    endgenerate
    assign core_awake_o = awake_reg;
    assign cal_start_o  = start_reg;

    // ***********************************************************
    // checks
    // ***********************************************************
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    disabled_goes_idle_a: assert property (
        !active |=> state_reg == lowpower_cal_pkg::ST_IDLE && awake_reg == '0)
        else $error("scheduler not idle while disabled");
    auto_sleep_end_a: assert property (
        active && !trig_mode && state_reg == lowpower_cal_pkg::ST_SLEEP
        && sleep_over |=> state_reg == lowpower_cal_pkg::ST_SETTLE)
        else $error("core did not wake after sleep interval");
    trigger_wake_a: assert property (
        active && trig_mode && state_reg == lowpower_cal_pkg::ST_SLEEP
        && !trig_level |=> state_reg == lowpower_cal_pkg::ST_SETTLE)
        else $error("low trigger did not wake core");
    sleep_not_early_a: assert property (
        !trig_mode && state_reg == lowpower_cal_pkg::ST_SLEEP && !sleep_over
        |=> state_reg != lowpower_cal_pkg::ST_SETTLE)
        else $error("core woke before sleep interval");
    settle_start_a: assert property (
        active && state_reg == lowpower_cal_pkg::ST_SETTLE && settle_over
        |=> cal_start_o != '0 ##1 cal_start_o == '0)
        else $error("calibration start not a single pulse after settle");
    control_reset_a: assert property (
        $fell(rst_i) |-> lowpower_cal_control_reg == `LPC_RST_CONTROL)
        else $error("control register reset value wrong");
    control_read_a: assert property (
        reg_rd_i && reg_addr_i == `LPC_ADDR_CONTROL
        |=> reg_rdata_o == $past(lowpower_cal_control_reg))
        else $error("control register read back wrong");
    soft_high_holds_a: assert property (
        trig_mode && !trigger_source_sel_reg && software_trigger_bit_reg
        && state_reg == lowpower_cal_pkg::ST_SLEEP
        |=> state_reg != lowpower_cal_pkg::ST_SETTLE)
        else $error("woke with software trigger held high");
    recycle_a: assert property (
        active && state_reg == lowpower_cal_pkg::ST_CAL && core_done
        |=> state_reg == lowpower_cal_pkg::ST_SLEEP
            && core_reg != $past(core_reg))
        else $error("core not returned to sleep after calibration");

endmodule // lowpower_cal_sleep_wake

// ---- shared/lowpower_cal_map.svh ----
// register map, field positions, reset values and delay counts
`ifndef LOWPOWER_CAL_MAP_SVH
`define LOWPOWER_CAL_MAP_SVH

// ***********************************************************
// register offsets
// ***********************************************************
`define LPC_ADDR_PIN_CFG      8'h6b
`define LPC_ADDR_SOFT_TRIG    8'h6c
`define LPC_ADDR_CONTROL      8'h6e
`define LPC_ADDR_STATUS       8'h6f
`define LPC_ADDR_BG_CTRL      8'h60

// ***********************************************************
// reset values
// ***********************************************************
`define LPC_RST_CONTROL       8'h88
`define LPC_RST_PIN_CFG       1'h0
`define LPC_RST_SOFT_TRIG     1'h1
`define LPC_RST_BG_CTRL       1'h0
`define LPC_RDATA_IDLE        8'h00

// ***********************************************************
// control field positions
// ***********************************************************
`define LPC_SLEEP_MSB         7
`define LPC_SLEEP_LSB         5
`define LPC_SETTLE_MSB        4
`define LPC_SETTLE_LSB        3
`define LPC_TRIG_MODE_BIT     1
`define LPC_ENABLE_BIT        0

// ***********************************************************
// delay counts: (2^n + 1) x 256 converter clock periods
// ***********************************************************
`define LPC_CNT_W             42
`define LPC_PERIODS(n)        (((42'h1 << (n)) + 42'h1) << 8)
`define LPC_SLEEP_CNT_0       `LPC_PERIODS(3)
`define LPC_SLEEP_CNT_1       `LPC_PERIODS(15)
`define LPC_SLEEP_CNT_2       `LPC_PERIODS(18)
`define LPC_SLEEP_CNT_3       `LPC_PERIODS(21)
`define LPC_SLEEP_CNT_4       `LPC_PERIODS(24)
`define LPC_SLEEP_CNT_5       `LPC_PERIODS(27)
`define LPC_SLEEP_CNT_6       `LPC_PERIODS(30)
`define LPC_SLEEP_CNT_7       `LPC_PERIODS(33)
`define LPC_SETTLE_CNT_0      `LPC_PERIODS(33)
`define LPC_SETTLE_CNT_1      `LPC_PERIODS(18)
`define LPC_SETTLE_CNT_2      `LPC_PERIODS(21)
`define LPC_SETTLE_CNT_3      `LPC_PERIODS(24)

`endif

// ---- shared/lowpower_cal_pkg.sv ----
// types shared by the low-power calibration scheduler
package lowpower_cal_pkg;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SLEEP,
        ST_SETTLE,
        ST_CAL
    } lpc_state_t;
endpackage

// ---- verif/trigger_source_model.sv ----
// far-side calibration trigger source driving the hardware pin
`timescale 1ns/1ps
module trigger_source_model (
    input  wire logic clk_sys_i,
    input  wire logic wake_req_i,
    output logic      hardware_trigger_pin_o
);
    // pin low wakes
    // idles high so an unwanted wake never leaks through
    initial hardware_trigger_pin_o = 1'b1;
    always @(posedge clk_sys_i)
        hardware_trigger_pin_o <= ~wake_req_i;
endmodule // trigger_source_model

// ---- verif/lowpower_cal_sleep_wake_tb.sv ----
// self-checking bench for the low-power calibration scheduler
`timescale 1ns/1ps
`include "lowpower_cal_map.svh"
module lowpower_cal_sleep_wake_tb;
    // shrunk counts keep the run short; index is the field code
    localparam logic [7:0][`LPC_CNT_W-1:0] SLP = {42'h9, 42'h8,
        42'h7, 42'h6, 42'h5, 42'h4, 42'h3, 42'h2};
    localparam logic [3:0][`LPC_CNT_W-1:0] SET = {42'h6, 42'h5,
        42'h4, 42'h3};
    logic       clk_sys_i = 1'b0;
    logic       rst_i     = 1'b1;
    logic [7:0] addr      = 8'h00;
    logic [7:0] wdata     = 8'h00;
    logic       wr        = 1'b0;
    logic       rd        = 1'b0;
    logic [7:0] rdata;
    logic       wake_req  = 1'b0;
    logic       pin;
    logic [1:0] done      = 2'h0;
    logic [1:0] awake;
    logic [1:0] start;
    logic [1:0] core      = 2'h1;
    int         failures  = 0;
    int         checks    = 0;
    always #10 clk_sys_i = ~clk_sys_i;
    lowpower_cal_sleep_wake #(.SLEEP_CYCLES(SLP), .SETTLE_CYCLES(SET))
        lowpower_cal_sleep_wake_inst (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .hardware_trigger_pin_i(pin),
        .cal_done_i(done), .core_awake_o(awake), .cal_start_o(start));
    trigger_source_model trigger_source_model_inst (
        .clk_sys_i(clk_sys_i), .wake_req_i(wake_req),
        .hardware_trigger_pin_o(pin));
    // ****************************************
    // tasks
    // ****************************************
    task automatic end_sim();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk8(input string n, input logic [7:0] e,
                        input logic [7:0] g);
        checks++;
        if (g !== e)
        begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chkn(input string n, input int e, input int g);
        checks++;
        if (g != e)
        begin
            failures++;
            $display("CHECK FAILED %s expected %0d seen %0d", n, e, g);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk_sys_i);
        wr    <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e,
                          input string n);
        @(posedge clk_sys_i);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk_sys_i);
        rd   <= 1'b0;
        #1 chk8(n, e, rdata);
    endtask
    // settled cycles until awake or start shows the expected core
    task automatic wait_for(input bit on_start, output int cnt);
        cnt = 0;
        while ((on_start ? start : awake) !== core)
        begin
            @(posedge clk_sys_i);
            #1 cnt++;
            if (cnt > 400)
            begin
                failures++;
                end_sim();
            end
        end
    endtask
    // one turn of the expected core; a register write lands during cal
    task automatic turn(input int es, input int et, input logic [7:0] wa,
                        input logic [7:0] wd);
        int c;
        wait_for(1'b0, c);
        if (es > 0)
            chkn("sleep cycles", es, c);
        wait_for(1'b1, c);
        chkn("settle cycles", et, c);
        @(posedge clk_sys_i);
        #1 chk8("start pulse", 8'h00, {6'h00, start});
        wr_reg(wa, wd);
        done <= core;
        #1 chk8("awake in cal", {6'h00, core}, {6'h00, awake});
        @(posedge clk_sys_i);
        done <= 2'h0;
        #1 chk8("awake after done", 8'h00, {6'h00, awake});
        core = {core[0], core[1]};
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        int i;
        logic [2:0] k;
        repeat (2) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        rd_reg(`LPC_ADDR_CONTROL, `LPC_RST_CONTROL, "ctrl reset");
        rd_reg(`LPC_ADDR_SOFT_TRIG, 8'h01, "soft trig reset");
        rd_reg(`LPC_ADDR_PIN_CFG, 8'h00, "source reset");
        rd_reg(8'h00, `LPC_RDATA_IDLE, "unmapped read");
        wr_reg(8'h00, 8'hff);
        wr_reg(`LPC_ADDR_CONTROL, 8'h5e);
        rd_reg(`LPC_ADDR_CONTROL, 8'h5e, "ctrl readback");
        // low codes used on purpose for short runs
        wr_reg(`LPC_ADDR_CONTROL, 8'h01);
        repeat (20) @(posedge clk_sys_i);
        #1 chk8("no bg enable", 8'h00, {6'h00, awake});
        wr_reg(`LPC_ADDR_BG_CTRL, 8'h01);
        for (i = 0; i < 8; i++)
        begin
            k = 3'(i + 1);
            turn(i == 0 ? 0 : int'(SLP[i]), int'(SET[i % 4]),
                 `LPC_ADDR_CONTROL,
                 i == 7 ? 8'h8b : {k, k[1:0], 3'h1});
        end
        repeat (20) @(posedge clk_sys_i);
        #1 chk8("trig held high", 8'h00, {6'h00, awake});
        rd_reg(`LPC_ADDR_STATUS, 8'h01, "status asleep");
        wr_reg(`LPC_ADDR_SOFT_TRIG, 8'h00);
        turn(0, int'(SET[1]), `LPC_ADDR_PIN_CFG, 8'h01);
        repeat (20) @(posedge clk_sys_i);
        #1 chk8("soft bit ignored", 8'h00, {6'h00, awake});
        rd_reg(`LPC_ADDR_STATUS, 8'h11, "status core1");
        @(posedge clk_sys_i);
        wake_req <= 1'b1;
        turn(0, int'(SET[1]), `LPC_ADDR_PIN_CFG, 8'h00);
        wait_for(1'b0, i);
        wr_reg(`LPC_ADDR_BG_CTRL, 8'h00);
        @(posedge clk_sys_i);
        #1 chk8("disable drops", 8'h00, {6'h00, awake});
        end_sim();
    end
endmodule // lowpower_cal_sleep_wake_tb
